//--- asb_pkg.sv
// Purpose: shared constants and types of the sample buffer
// Assumes: 32-bit AXI4-Lite register bus, 8-bit register offsets
// Notes:   one packed struct carries the registered state of the top module, the sample store apart
package asb_pkg;
  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] ASB_OFF_CTRL   = 8'h00; // mode, resolution
  localparam logic [7:0] ASB_OFF_RATE   = 8'h04; // output rate period
  localparam logic [7:0] ASB_OFF_THRESH = 8'h08; // sample threshold
  localparam logic [7:0] ASB_OFF_STAT   = 8'h0C; // level, flags
  localparam logic [7:0] ASB_OFF_EXCESS = 8'h10; // samples above threshold
  localparam logic [7:0] ASB_OFF_CLEAR  = 8'h14; // any write empties
  localparam logic [7:0] ASB_OFF_DATA   = 8'h18; // buffer output byte
  // ****************************************
  // field layout and sizes
  // ****************************************
  localparam int ASB_BIT_RES   = 2;  // resolution select in control
  localparam int ASB_BIT_WM    = 16; // watermark in status
  localparam int ASB_BIT_TRIG  = 17; // trigger flag in status
  localparam int ASB_CAP       = 2048; // bytes of sample store
  localparam logic [11:0] ASB_CAP12 = 12'h0800; // capacity, count width
  localparam logic [2:0] ASB_LO_SZ = 3'h3; // bytes per sample, 8-bit
  localparam logic [2:0] ASB_HI_SZ = 3'h6; // bytes per sample, 16-bit
  localparam logic [1:0] ASB_OKAY   = 2'h0; // axi response okay
  localparam logic [1:0] ASB_SLVERR = 2'h2; // axi response, unmapped
  localparam logic [15:0] ASB_RATE_RST = 16'h0000; // rate reset value
  localparam logic [9:0]  ASB_TH_RST   = 10'h000;  // threshold reset

  // buffer operating modes as software encodes them
  typedef enum logic [1:0] {
    ASB_FIFO   = 2'h0,
    ASB_STREAM = 2'h1,
    ASB_TRIG   = 2'h2,
    ASB_NEWEST_FIRST_MODE = 2'h3
  } asb_mode_t;

  // one sample of three axes
  typedef struct packed {
    logic [15:0] x; // x axis
    logic [15:0] y; // y axis
    logic [15:0] z; // z axis
  } asb_sample_t;

  // registered state of the buffer block, except the sample store
  typedef struct packed {
    asb_mode_t   mode;   // operating mode
    logic        res;    // resolution select
    logic [15:0] rate;   // output rate select, period minus one
    logic [9:0]  th;     // sample threshold field
    logic [15:0] div;    // rate divider
    logic [10:0] wr_ptr; // next byte to write
    logic [10:0] rd_ptr; // oldest byte
    logic [11:0] count;  // stored bytes
    logic        trig;   // trigger status flag
    logic        wm;     // watermark
    logic        aw_hold; // write address held
    logic [7:0]  awaddr;  // held write address
    logic        w_hold;  // write data held
    logic [31:0] wdata;   // held write data
    logic [3:0]  wstrb;   // held byte enables
    logic        bvalid;  // write response pending
    logic [1:0]  bresp;   // write response code
    logic        rvalid;  // read data pending
    logic [31:0] rdata;   // read data
    logic [1:0]  rresp;   // read response code
  } asb_state_t;
endpackage : asb_pkg

//--- asb_top.sv
// Purpose: byte-wide accelerometer sample buffer with four modes
// Assumes: samples and detection interrupt come from logic on aclk
// Notes:   reads of every register stall for the cycle of an output rate tick

// Overview of operation
// - four modes, 8 or 16 bit samples
// - one sample per output rate period
// - fifo mode stops storing when full
// - fifo reads oldest sample, first byte first
// - stream and newest-first discard oldest when full
// - stream and trigger read oldest first
// - newest-first reads newest sample, last byte first
// - watermark while sample count at or above threshold, except in trigger mode
// - excess equals level over size minus threshold
// - trigger keeps pre-event samples, fills until full
// - trigger flag on interrupt with enough samples
// - clear write empties store, and trigger flag unless the trigger condition holds in that cycle
// - before trigger, threshold reached displaces oldest
// - reading the data register removes one byte, the newest in newest-first, else the oldest
module asb_top (
  input  wire logic                aclk,          // 40 MHz clock
  input  wire logic                aresetn,       // sync reset, low
  input  wire asb_pkg::asb_sample_t sample,       // current acceleration
  input  wire logic                engine_irq,    // detection interrupt
  output logic                     watermark,     // watermark level
  output logic                     trigger_status_flag, // trigger seen
  input  wire logic [7:0]          s_axi_awaddr,  // write address
  input  wire logic                s_axi_awvalid, // write address valid
  output logic                     s_axi_awready, // write address ready
  input  wire logic [31:0]         s_axi_wdata,   // write data
  input  wire logic [3:0]          s_axi_wstrb,   // byte enables
  input  wire logic                s_axi_wvalid,  // write data valid
  output logic                     s_axi_wready,  // write data ready
  output logic [1:0]               s_axi_bresp,   // write response
  output logic                     s_axi_bvalid,  // write response valid
  input  wire logic                s_axi_bready,  // write response ready
  input  wire logic [7:0]          s_axi_araddr,  // read address
  input  wire logic                s_axi_arvalid, // read address valid
  output logic                     s_axi_arready, // read address ready
  output logic [31:0]              s_axi_rdata,   // read data
  output logic [1:0]               s_axi_rresp,   // read response
  output logic                     s_axi_rvalid,  // read data valid
  input  wire logic                s_axi_rready   // read data ready
);
  import asb_pkg::*;

  // ****************************************
  // storage and working signals
  // ****************************************
  logic [7:0]  mem [ASB_CAP];     // sample store
  asb_state_t  s;                 // registered state
  asb_state_t  next_s;            // next state
  logic        tick;              // output rate pulse
  logic [2:0]  ssize;             // bytes per sample
  logic [11:0] ss12;              // bytes per sample, count width
  logic [10:0] samples;           // whole samples stored
  logic        room;              // one more sample fits
  logic        wr_do;             // store a sample this cycle
  logic        disc;              // drop the oldest sample
  logic        clr;               // clear register written
  logic        wfire;             // register write performed
  logic        trig_set;          // trigger condition this cycle
  logic [7:0]  sb [6];            // sample bytes in store order
  logic [31:0] wmask;             // byte enable mask
  logic [11:0] excess_sample_count; // samples above threshold
  logic [31:0] rd_word;           // decoded read word
  logic [1:0]  rd_resp;           // decoded read response

  // handshakes are combinational
  assign s_axi_awready = !s.aw_hold && !s.bvalid;
  assign s_axi_wready  = !s.w_hold && !s.bvalid;
  // a sample write owns the pointers for its cycle
  assign s_axi_arready = !s.rvalid && !tick;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign watermark     = s.wm;
  assign trigger_status_flag = s.trig;

  // ****************************************
  // derived buffer quantities
  // ****************************************
  always_comb begin
    ssize = s.res ? ASB_HI_SZ : ASB_LO_SZ;
    ss12  = {9'h000, ssize};
    samples = s.res ? 11'(s.count / ASB_HI_SZ) : 11'(s.count / ASB_LO_SZ);
    excess_sample_count = {1'b0, samples} - {2'h0, s.th};
    room = (s.count + ss12) <= ASB_CAP12;
    tick = (s.div == s.rate);
    wmask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
             {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
    wfire = s.aw_hold && s.w_hold && !s.bvalid;
    clr   = wfire && (s.awaddr == ASB_OFF_CLEAR);
    trig_set = (s.mode == ASB_TRIG) && engine_irq && (samples >= 11'(s.th));
  end

  // sample bytes: low byte first at high resolution, high bytes at low
  always_comb begin
    if (s.res) begin
      sb = '{sample.x[7:0], sample.x[15:8], sample.y[7:0],
             sample.y[15:8], sample.z[7:0], sample.z[15:8]};
    end else begin
      sb = '{sample.x[15:8], sample.y[15:8], sample.z[15:8],
             8'h00, 8'h00, 8'h00};
    end
  end

  // ****************************************
  // accumulation policy per mode
  // ****************************************
  always_comb begin
    wr_do = 1'b0;
    disc  = 1'b0;
    if (tick && !clr) begin
      unique case (s.mode)
        ASB_FIFO: wr_do = room;
        ASB_STREAM, ASB_NEWEST_FIRST_MODE: begin
          wr_do = 1'b1;
          disc  = !room;
        end
        ASB_TRIG: begin
          if (!s.trig) begin
            disc  = (samples >= 11'(s.th)) && (s.count != 12'h000);
            wr_do = room || disc;
          end else begin
            wr_do = room;
          end
        end
      endcase
    end
  end

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = ASB_OKAY;
    unique case (s_axi_araddr)
      ASB_OFF_CTRL:   rd_word = {29'h0000_0000, s.res, s.mode};
      ASB_OFF_RATE:   rd_word = {16'h0000, s.rate};
      ASB_OFF_THRESH: rd_word = {22'h00_0000, s.th};
      ASB_OFF_STAT: begin
        rd_word[10:0]        = s.count[10:0];
        rd_word[ASB_BIT_WM]  = s.wm;
        rd_word[ASB_BIT_TRIG] = s.trig;
      end
      ASB_OFF_EXCESS: rd_word = {20'h0_0000, excess_sample_count};
      ASB_OFF_CLEAR:  rd_word = 32'h0000_0000;
      ASB_OFF_DATA: begin
        if (s.count != 12'h000) begin
          // newest byte sits below write pointer
          if (s.mode == ASB_NEWEST_FIRST_MODE) begin
            rd_word = {24'h00_0000, mem[11'(s.wr_ptr - 11'h001)]};
          end else begin
            rd_word = {24'h00_0000, mem[s.rd_ptr]};
          end
        end
      end
      default: rd_resp = ASB_SLVERR;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.div = tick ? 16'h0000 : 16'(s.div + 16'h0001);
    // pointer movement from sample accumulation
    if (disc) begin
      next_s.rd_ptr = 11'(s.rd_ptr + 11'(ssize));
    end
    if (wr_do) begin
      next_s.wr_ptr = 11'(s.wr_ptr + 11'(ssize));
    end
    next_s.count = s.count + (wr_do ? ss12 : 12'h000)
                   - (disc ? ss12 : 12'h000);
    // axi write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_hold = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_hold = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wfire) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = ASB_OKAY;
      unique case (s.awaddr)
        ASB_OFF_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.mode = asb_mode_t'(s.wdata[1:0]);
            next_s.res  = s.wdata[ASB_BIT_RES];
          end
        end
        ASB_OFF_RATE: next_s.rate = 16'((s.rate & wmask[15:0])
                                  ^ s.rate ^ (s.wdata[15:0] & wmask[15:0]));
        ASB_OFF_THRESH: next_s.th = 10'((s.th & wmask[9:0]) ^ s.th
                                  ^ (s.wdata[9:0] & wmask[9:0]));
        ASB_OFF_CLEAR: begin
          next_s.wr_ptr = 11'h000;
          next_s.rd_ptr = 11'h000;
          next_s.count  = 12'h000;
          next_s.trig   = 1'b0;
        end
        ASB_OFF_STAT, ASB_OFF_EXCESS, ASB_OFF_DATA: ;
        default: next_s.bresp = ASB_SLVERR;
      endcase
    end
    if (trig_set) begin
      next_s.trig = 1'b1;
    end
    // axi read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word;
      next_s.rresp  = rd_resp;
      if ((s_axi_araddr == ASB_OFF_DATA) && (s.count != 12'h000) && !clr) begin
        next_s.count = 12'(s.count - 12'h001);
        if (s.mode == ASB_NEWEST_FIRST_MODE) begin
          next_s.wr_ptr = 11'(s.wr_ptr - 11'h001);
        end else begin
          next_s.rd_ptr = 11'(s.rd_ptr + 11'h001);
        end
      end
    end
    next_s.wm = (s.mode != ASB_TRIG) && (samples >= 11'(s.th));
  end
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0;
      s.mode <= ASB_FIFO;
      s.rate <= ASB_RATE_RST;
      s.th   <= ASB_TH_RST;
      s.wm   <= (ASB_TH_RST == 10'h000); // empty store meets zero threshold
    end else begin
      s <= next_s;
    end
  end

  // sample store write, all bytes of one sample in one cycle
  always_ff @(posedge aclk) begin
    if (wr_do) begin
      for (int i = 0; i < 6; i++) begin
        if (3'(i) < ssize) begin
          mem[11'(s.wr_ptr + 11'(i))] <= sb[i];
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence seq_fill_tick;
    tick && !clr && !room;
  endsequence

  AST_FIFO_FULL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == ASB_FIFO) and seq_fill_tick |=> s.count == $past(s.count))
    else $error("fifo stored a sample while full");

  AST_RATE_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !clr && (s.mode == ASB_STREAM) |=> s.wr_ptr != $past(s.wr_ptr))
    else $error("stream sample not stored on tick");

  AST_STREAM_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.mode == ASB_STREAM) and seq_fill_tick
    |=> s.rd_ptr == 11'($past(s.rd_ptr) + 11'($past(ssize))))
    else $error("oldest sample not discarded");

  sequence seq_data_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == ASB_OFF_DATA)
    && (s.count != 12'h000) && !clr;
  endsequence

  AST_OLDEST_POP: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_data_read and (s.mode != ASB_NEWEST_FIRST_MODE)
    |=> s.rvalid && (s.rd_ptr == 11'($past(s.rd_ptr) + 11'h001))
        && (s.count == 12'($past(s.count) - 12'h001)))
    else $error("oldest-first read did not advance");

  AST_NEWEST_POP: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_data_read and (s.mode == ASB_NEWEST_FIRST_MODE)
    |=> s.wr_ptr == 11'($past(s.wr_ptr) - 11'h001))
    else $error("newest-first read did not step back");

  AST_WATERMARK: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 watermark == ($past(s.mode) != ASB_TRIG
                      && $past(samples) >= 11'($past(s.th))))
    else $error("watermark disagrees with sample count");

  AST_TRIG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_set |=> trigger_status_flag)
    else $error("trigger flag not set");

  AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    clr && !trig_set |=> (s.count == 12'h000) && !s.trig)
    else $error("clear did not empty the buffer");

  AST_LEVEL_CAP: assert property (@(posedge aclk) disable iff (!aresetn)
    s.count <= ASB_CAP12)
    else $error("level exceeds store capacity");
endmodule : asb_top

//--- asb_src_model.sv
// Purpose: front end model that feeds samples and detection events
// Assumes: the bench calls its tasks just after a rising edge of aclk
// Notes:   values move only on an edge, never mid-cycle
module asb_src_model (
  input  wire logic            aclk,       // bench clock
  output asb_pkg::asb_sample_t sample,     // held acceleration
  output logic                 engine_irq  // detection pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  import asb_pkg::*;

  // quiet front end until the bench asks for something
  initial begin
    sample = '0;
    engine_irq = 1'b0;
  end

  // hold a new acceleration value from the next edge on
  task put(input asb_sample_t v);
    @(posedge aclk);
    sample <= v;
  endtask : put

  // one-cycle event from a detection engine
  task fire();
    @(posedge aclk);
    engine_irq <= 1'b1;
    @(posedge aclk);
    engine_irq <= 1'b0;
  endtask : fire
endmodule : asb_src_model

//--- tb_top.sv
// Purpose: self-checking bench of the sample buffer over its register bus
// Assumes: rate 1 gives a sample every two cycles, store fills in ~700
// Notes:   read and write results are queued and judged by a monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asb_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  typedef struct {
    string       nm; // what is checked
    logic [31:0] d;  // expected data
    logic [31:0] m;  // bits that matter
    logic [1:0]  r;  // expected response
  } asb_note_t;
  logic        aclk, aresetn, wm, tflag;          // clock, reset, flags
  logic        awvalid, awready, wvalid, wready;  // write request side
  logic        bvalid, bready, arvalid, arready;  // handshakes
  logic        rvalid, rready;                    // read response
  logic [7:0]  awaddr, araddr;                    // addresses
  logic [31:0] wdata, rdata;                      // data words
  logic [3:0]  wstrb;                             // byte enables
  logic [1:0]  bresp, rresp;                      // response codes
  asb_sample_t pretrigger_sample_count, s1, s2, s4;                   // samples in play
  logic        irq;                               // detection event
  asb_note_t   rq[$], wq[$], nt;                  // pending notes
  int          n_fail, checks;                    // verdict counters
  integer      seed = 32'h293001e0;               // fixed random seed

  asb_top asb_top_inst (
    .aclk(aclk), .aresetn(aresetn), .sample(pretrigger_sample_count), .engine_irq(irq),
    .watermark(wm), .trigger_status_flag(tflag),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  asb_src_model asb_src_model_inst (
    .aclk(aclk), .sample(pretrigger_sample_count), .engine_irq(irq));

  // ****************************************
  // helpers
  // ****************************************
  // free-running 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // one comparison, reported at once when it differs
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // byte k of a 16-bit sample in storage order, x low byte first
  function automatic logic [7:0] hb(input asb_sample_t s, input int k);
    logic [47:0] v;
    v = {s.z, s.y, s.x};
    return v[8*k +: 8];
  endfunction : hb

  // random sample drawn from the fixed seed
  function asb_sample_t rnd();
    logic [63:0] v;
    v = {$random(seed), $random(seed)};
    return v[47:0];
  endfunction : rnd

  // addresses past the data register are unmapped
  function automatic logic [1:0] rsp(input logic [7:0] a);
    return (a > ASB_OFF_DATA) ? ASB_SLVERR : ASB_OKAY;
  endfunction : rsp

  // write: address and data offered together, response awaited
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wq.push_back('{"write", 32'h0, 32'h0, rsp(a)});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    bready <= 1'b0;
  endtask : wr

  // read: note the expectation, then hold the request until taken
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
          input string nm);
    int n;
    n = 0;
    rq.push_back('{nm, d, m, rsp(a)});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    rready <= 1'b0;
  endtask : rd

  task idle(input int c);
    repeat (c) @(posedge aclk);
  endtask : idle

  // monitor: each answer taken off the bus meets its oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      nt = rq.pop_front();
      chk(nt.nm, rdata & nt.m, nt.d);
      chk({nt.nm, " resp"}, {30'h0, rresp}, {30'h0, nt.r});
    end
    if (bvalid === 1'b1 && bready && wq.size() > 0) begin
      nt = wq.pop_front();
      chk("write resp", {30'h0, bresp}, {30'h0, nt.r});
    end
  end

  // verdict, reached from the sequence end and from the watchdog
  task end_sim();
    if (rq.size() + wq.size() > 0) n_fail++;
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // watchdog: the sequence needs about 4700 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_sim();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset watermark", {31'h0, wm}, 32'h0000_0001);
    wr(ASB_OFF_RATE, 32'h0000_0001);
    rd(ASB_OFF_RATE, 32'h0000_0001, 32'h0000_FFFF, "rate");
    rd(ASB_OFF_THRESH, 32'h0000_0000, 32'h0000_03FF, "thresh rst");
    wr(ASB_OFF_THRESH, 32'h0000_000A);
    // fifo at 16 bits: fills, then refuses, oldest byte first
    s1 = rnd();
    asb_src_model_inst.put(s1);
    wr(ASB_OFF_CTRL, 32'h0000_0004);
    wr(ASB_OFF_CLEAR, 32'h0000_0000);
    idle(800);
    s2 = rnd();
    asb_src_model_inst.put(s2);
    idle(20);
    rd(ASB_OFF_STAT, 32'h0001_07FE, 32'h0001_07FF, "fifo full");
    rd(ASB_OFF_EXCESS, 32'h0000_014B, 32'h0000_0FFF, "excess");
    for (int k = 0; k < 12; k++)
      rd(ASB_OFF_DATA, {24'h0, hb(s1, k % 6)}, 32'hFF, "fifo byte");
    wr(ASB_OFF_THRESH, 32'h0000_03E8);
    idle(20);
    chk("wm above count", {31'h0, wm}, 32'h0000_0000);
    rd(ASB_OFF_EXCESS, 32'h0000_0D6D, 32'h0000_0FFF, "neg excess");
    // stream: old samples give way, reads stay oldest first
    wr(ASB_OFF_CTRL, 32'h0000_0005);
    idle(1000);
    asb_src_model_inst.put(rnd());
    for (int k = 0; k < 6; k++)
      rd(ASB_OFF_DATA, {24'h0, hb(s2, k)}, 32'hFF, "stream byte");
    // newest-first at 8 bits: keeps storing when full, newest z first
    wr(ASB_OFF_THRESH, 32'h0000_01F4);
    s4 = rnd();
    asb_src_model_inst.put(s4);
    wr(ASB_OFF_CTRL, 32'h0000_0003);
    wr(ASB_OFF_CLEAR, 32'h0000_0000);
    idle(1500);
    rd(ASB_OFF_STAT, 32'h0001_07FE, 32'h0001_07FF, "low res full");
    rd(ASB_OFF_EXCESS, 32'h0000_00B6, 32'h0000_0FFF, "low excess");
    chk("wm reached", {31'h0, wm}, 32'h0000_0001);
    rd(ASB_OFF_DATA, {24'h0, s4.z[15:8]}, 32'hFF, "newest byte");
    // trigger: pre-event window, event flag, fill, then clear
    wr(ASB_OFF_THRESH, 32'h0000_0005);
    wr(ASB_OFF_CTRL, 32'h0000_0006);
    wr(ASB_OFF_CLEAR, 32'h0000_0000);
    idle(100);
    rd(ASB_OFF_STAT, 32'h0000_001E, 32'h0003_07FF, "pre window");
    chk("wm in trigger", {31'h0, wm}, 32'h0000_0000);
    asb_src_model_inst.fire();
    idle(4);
    chk("trigger flag", {31'h0, tflag}, 32'h0000_0001);
    idle(1000);
    rd(ASB_OFF_STAT, 32'h0002_07FE, 32'h0003_07FF, "after event");
    // the host reads only once the flag is up
    for (int k = 0; k < 6; k++)
      rd(ASB_OFF_DATA, {24'h0, hb(s4, k)}, 32'hFF, "trig byte");
    wr(ASB_OFF_CLEAR, 32'h0000_0000);
    idle(2);
    chk("flag cleared", {31'h0, tflag}, 32'h0000_0000);
    // unmapped places answer with an error and no data
    rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
    wr(8'h20, 32'h0000_00FF);
    idle(4);
    end_sim();
  end
endmodule : tb_top
